//--- core/lpbf_core.sv
// LED PWM generation with bank control, power save and fault reporting.
// Assumes synchronous detector inputs and one AHB-Lite master, word access only.
`timescale 1ns/100ps
module lpbf_core import lpbf_pkg::*; #(
  parameter int PS_LIMIT = PS_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NCH-1:0] openDetect,
  input wire logic [NCH-1:0] shortDetect,
  input wire logic heatDetect,
  input wire logic thermalShutdown,
  input wire logic supplyWarnDetect,
  input wire logic supplyLowLockout,
  output logic [NCH-1:0] sinkOutput,
  output logic analogPowerDown,
  output logic faultPinOut,
  output logic faultPinOe
);
  logic wrPendFf, rdPendFf;
  logic [6:0] addrFf;
  logic [31:0] hrdataFf;
  logic [31:0] rdMux;
  logic [7:0] shadeFf [NCH];
  logic [7:0] intensFf [NMOD];
  logic [7:0] bankShadeFf [NBANK];
  logic [7:0] bankIntensFf;
  logic [NMOD-1:0] grpSelFf;
  logic psEnFf;
  logic [1:0] waitSelFf;
  logic [4:0] maskGFf;
  logic [NCH-1:0] openMskFf, shortMskFf;
  logic [NCH-1:0] openFlFf, shortFlFf;
  logic gOpenFf, gShortFf, heatFlFf, supFlFf, porFlFf;
  logic [5:0] openCntFf [NCH];
  logic [5:0] shortCntFf [NCH];
  logic [10:0] heatCntFf, supCntFf;
  logic [20:0] psCntFf;
  logic [8:0] pwmCntFf;
  lpbf_state_t stateFf, nxt_state;
  logic [NCH-1:0] lit, openEv, shortEv;
  logic [NCH-1:0] sinkFf;
  logic faultFf;
  logic anyLit;

  // Bus decode
  wire busTake = hsel & htrans[1] & hready;
  wire wrCtrl = wrPendFf & (addrFf == IDX_CTRL);
  wire clrFault = wrCtrl & hwdata[CTRL_CLR];
  wire clrPor = wrCtrl & hwdata[CTRL_PORCLR];
  wire [6:0] intIdx = addrFf - IDX_INTENS;
  wire [6:0] shdIdx = addrFf - IDX_SHADE;
  wire isIntens = (addrFf >= IDX_INTENS) && (intIdx < 7'(NMOD));
  wire isShade = (addrFf >= IDX_SHADE) && (shdIdx < 7'(NCH));
  wire [5:0] waitCnt = 6'({waitSelFf, 3'b000}) + WAIT_UNIT;
  wire heatEv = heatDetect & (heatCntFf >= WARN_CYCLES);
  wire supEv = supplyWarnDetect & (supCntFf >= WARN_CYCLES);

  // Reads take one wait state so read data comes straight from a flop
  assign hreadyout = ~rdPendFf;
  assign hresp = 1'b0;
  assign hrdata = hrdataFf;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (addrFf)
      IDX_CTRL: rdMux = {27'h0, 2'b00, waitSelFf, psEnFf};
      IDX_GSEL_LO: rdMux = {24'h0, grpSelFf[7:0]};
      IDX_GSEL_HI: rdMux = {28'h0, grpSelFf[NMOD-1:8]};
      IDX_BANK: rdMux = {bankIntensFf, bankShadeFf[2], bankShadeFf[1], bankShadeFf[0]};
      IDX_STAT: rdMux = {25'h0, thermalShutdown, stateFf == ST_PSAVE, porFlFf, supFlFf,
                         heatFlFf, gShortFf, gOpenFf};
      IDX_MASKG: rdMux = {27'h0, maskGFf};
      IDX_OFL_LO: rdMux = openFlFf[31:0];
      IDX_OFL_HI: rdMux = {28'h0, openFlFf[NCH-1:32]};
      IDX_SFL_LO: rdMux = shortFlFf[31:0];
      IDX_SFL_HI: rdMux = {28'h0, shortFlFf[NCH-1:32]};
      IDX_OMSK_LO: rdMux = openMskFf[31:0];
      IDX_OMSK_HI: rdMux = {28'h0, openMskFf[NCH-1:32]};
      IDX_SMSK_LO: rdMux = shortMskFf[31:0];
      IDX_SMSK_HI: rdMux = {28'h0, shortMskFf[NCH-1:32]};
      default: begin
        if (isIntens) begin
          rdMux = {24'h0, intensFf[intIdx[3:0]]};
        end else if (isShade) begin
          rdMux = {24'h0, shadeFf[shdIdx[5:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPendFf <= 1'b0;
      rdPendFf <= 1'b0;
      addrFf <= 7'h00;
      hrdataFf <= 32'h0000_0000;
    end else begin
      wrPendFf <= busTake & hwrite;
      rdPendFf <= busTake & ~hwrite;
      addrFf <= busTake ? haddr[8:2] : addrFf;
      hrdataFf <= rdPendFf ? rdMux : hrdataFf;
    end
  end

  // Configuration; lockout acts as a held internal reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) shadeFf[i] <= SHADE_RST;
      for (int i = 0; i < NMOD; i++) intensFf[i] <= INTENS_RST;
      for (int i = 0; i < NBANK; i++) bankShadeFf[i] <= SHADE_RST;
      bankIntensFf <= INTENS_RST;
      grpSelFf <= '0;
      psEnFf <= PSEN_RST;
      waitSelFf <= 2'b00;
      maskGFf <= 5'h00;
      openMskFf <= '0;
      shortMskFf <= '0;
    end else if (supplyLowLockout) begin
      for (int i = 0; i < NCH; i++) shadeFf[i] <= SHADE_RST;
      for (int i = 0; i < NMOD; i++) intensFf[i] <= INTENS_RST;
      for (int i = 0; i < NBANK; i++) bankShadeFf[i] <= SHADE_RST;
      bankIntensFf <= INTENS_RST;
      grpSelFf <= '0;
      psEnFf <= PSEN_RST;
      waitSelFf <= 2'b00;
      maskGFf <= 5'h00;
      openMskFf <= '0;
      shortMskFf <= '0;
    end else if (wrPendFf) begin
      case (addrFf)
        IDX_CTRL: begin
          psEnFf <= hwdata[CTRL_PSEN];
          waitSelFf <= hwdata[CTRL_WSEL+:2];
        end
        IDX_GSEL_LO: grpSelFf[7:0] <= hwdata[7:0];
        IDX_GSEL_HI: grpSelFf[NMOD-1:8] <= hwdata[3:0];
        IDX_BANK: begin
          bankShadeFf[0] <= hwdata[7:0];
          bankShadeFf[1] <= hwdata[15:8];
          bankShadeFf[2] <= hwdata[23:16];
          bankIntensFf <= hwdata[31:24];
        end
        IDX_MASKG: maskGFf <= hwdata[4:0];
        IDX_OMSK_LO: openMskFf[31:0] <= hwdata;
        IDX_OMSK_HI: openMskFf[NCH-1:32] <= hwdata[3:0];
        IDX_SMSK_LO: shortMskFf[31:0] <= hwdata;
        IDX_SMSK_HI: shortMskFf[NCH-1:32] <= hwdata[3:0];
        default: begin
          if (isIntens) intensFf[intIdx[3:0]] <= hwdata[7:0];
          if (isShade) shadeFf[shdIdx[5:0]] <= hwdata[7:0];
        end
      endcase
    end
  end

  // PWM: 512-clock period, duty is the top bits of shade times intensity
  generate
    for (genvar n = 0; n < NCH; n++) begin : g_ch
      localparam int M = n / 3;
      wire [7:0] shade = grpSelFf[M] ? bankShadeFf[n % 3] : shadeFf[n];
      wire [7:0] intens = grpSelFf[M] ? bankIntensFf : intensFf[M];
      wire [15:0] prod = shade * intens;
      wire [9:0] duty = {1'b0, prod[15:7]};
      wire [9:0] cnt = {1'b0, pwmCntFf};
      wire [9:0] start = PWM_HALF - {2'b00, duty[8:1]};
      if (n % 3 == 0) begin : g_a
        assign lit[n] = cnt < duty;
      end else if (n % 3 == 1) begin : g_b
        assign lit[n] = (cnt >= start) && (cnt < start + duty);
      end else begin : g_c
        assign lit[n] = (cnt + duty) >= PWM_PERIOD;
      end
      assign openEv[n] = openDetect[n] & (openCntFf[n] >= waitCnt);
      assign shortEv[n] = shortDetect[n] & (shortCntFf[n] >= waitCnt);
    end
  endgenerate

  always_comb begin
    anyLit = bankIntensFf != 8'h00;
    for (int i = 0; i < NBANK; i++) anyLit = anyLit | (bankShadeFf[i] != 8'h00);
    for (int i = 0; i < NMOD; i++) anyLit = anyLit | (intensFf[i] != 8'h00);
    for (int i = 0; i < NCH; i++) anyLit = anyLit | (shadeFf[i] != 8'h00);
  end

  wire psGo = psEnFf & ~anyLit & (psCntFf >= 21'(PS_LIMIT));

  always_comb begin
    case (stateFf)
      ST_INIT: nxt_state = ST_NORMAL;
      ST_NORMAL: nxt_state = psGo ? ST_PSAVE : ST_NORMAL;
      ST_PSAVE: nxt_state = (busTake | anyLit) ? ST_NORMAL : ST_PSAVE;
      default: nxt_state = ST_INIT;
    endcase
    if (supplyLowLockout) nxt_state = ST_INIT;
  end

  // Only lockout and thermal shutdown stop the drivers; other faults only report
  wire drvEn = (stateFf == ST_NORMAL) & ~thermalShutdown;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stateFf <= ST_INIT;
      psCntFf <= 21'h0;
      pwmCntFf <= 9'h000;
      sinkFf <= '0;
    end else begin
      stateFf <= nxt_state;
      psCntFf <= (stateFf != ST_NORMAL || anyLit || !psEnFf) ? 21'h0 :
                 (psCntFf >= 21'(PS_LIMIT)) ? psCntFf : psCntFf + 21'h1;
      pwmCntFf <= pwmCntFf + 9'h001;
      sinkFf <= lit & {NCH{drvEn}};
    end
  end
  assign sinkOutput = sinkFf;
  assign analogPowerDown = stateFf == ST_PSAVE;

  // Fault filters and sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) openCntFf[i] <= 6'h00;
      for (int i = 0; i < NCH; i++) shortCntFf[i] <= 6'h00;
      heatCntFf <= 11'h000;
      supCntFf <= 11'h000;
      openFlFf <= '0;
      shortFlFf <= '0;
      gOpenFf <= 1'b0;
      gShortFf <= 1'b0;
      heatFlFf <= 1'b0;
      supFlFf <= 1'b0;
      porFlFf <= 1'b1;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        openCntFf[i] <= !openDetect[i] ? 6'h00 :
                        (openCntFf[i] >= waitCnt) ? openCntFf[i] : openCntFf[i] + 6'h01;
        shortCntFf[i] <= !shortDetect[i] ? 6'h00 :
                         (shortCntFf[i] >= waitCnt) ? shortCntFf[i] : shortCntFf[i] + 6'h01;
      end
      heatCntFf <= !heatDetect ? 11'h000 : heatEv ? heatCntFf : heatCntFf + 11'h001;
      supCntFf <= !supplyWarnDetect ? 11'h000 : supEv ? supCntFf : supCntFf + 11'h001;
      if (supplyLowLockout) begin
        openFlFf <= '0;
        shortFlFf <= '0;
        gOpenFf <= 1'b0;
        gShortFf <= 1'b0;
        heatFlFf <= 1'b0;
        supFlFf <= 1'b0;
        porFlFf <= 1'b1;
      end else begin
        openFlFf <= openEv | (openFlFf & ~{NCH{clrFault}});
        shortFlFf <= shortEv | (shortFlFf & ~{NCH{clrFault}});
        gOpenFf <= (|openEv) | (gOpenFf & ~clrFault);
        gShortFf <= (|shortEv) | (gShortFf & ~clrFault);
        heatFlFf <= heatEv | (heatFlFf & ~clrFault);
        supFlFf <= supEv | (supFlFf & ~clrFault);
        porFlFf <= porFlFf & ~clrPor;
      end
    end
  end

  // Fault pin: unmasked flags plus live lockout and shutdown
  wire openRep = (|(openFlFf & ~openMskFf)) & ~maskGFf[0];
  wire shortRep = (|(shortFlFf & ~shortMskFf)) & ~maskGFf[1];
  wire warnRep = (heatFlFf & ~maskGFf[2]) | (supFlFf & ~maskGFf[3]) |
                 (porFlFf & ~maskGFf[4]);
  wire faultAny = openRep | shortRep | warnRep | thermalShutdown | supplyLowLockout;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      faultFf <= 1'b0;
    end else begin
      faultFf <= faultAny;
    end
  end
  assign faultPinOut = 1'b0;
  assign faultPinOe = faultFf;

  a_fault_level: assert property (@(posedge clock) disable iff (!nrst)
    faultAny |=> faultPinOe) else $error("fault pin not driven for a standing fault");
  a_fault_release: assert property (@(posedge clock) disable iff (!nrst)
    !faultAny |=> !faultPinOe) else $error("fault pin driven with no fault");
  a_tsd_off: assert property (@(posedge clock) disable iff (!nrst)
    thermalShutdown |=> sinkOutput == '0) else $error("outputs on during shutdown");
  a_lockout_init: assert property (@(posedge clock) disable iff (!nrst)
    supplyLowLockout |=> stateFf == ST_INIT && porFlFf && faultPinOe)
    else $error("lockout did not hold init");
  a_ps_exit: assert property (@(posedge clock) disable iff (!nrst)
    (stateFf == ST_PSAVE && busTake && !supplyLowLockout) |=> stateFf == ST_NORMAL)
    else $error("bus command did not leave power save");
  a_ps_entry: assert property (@(posedge clock) disable iff (!nrst)
    (stateFf == ST_NORMAL ##1 stateFf == ST_PSAVE) |-> $past(psCntFf) >= 21'(PS_LIMIT)
    && !$past(anyLit)) else $error("power save entered too early");
  a_heat_filter: assert property (@(posedge clock) disable iff (!nrst)
    $rose(heatFlFf) |-> $past(heatCntFf) == WARN_CYCLES && $past(heatDetect))
    else $error("heat flag set before filter time");
  a_supply_filter: assert property (@(posedge clock) disable iff (!nrst)
    $rose(supFlFf) |-> $past(supCntFf) == WARN_CYCLES && $past(supplyWarnDetect))
    else $error("supply flag set before filter time");
  a_open_filter: assert property (@(posedge clock) disable iff (!nrst)
    $rose(openFlFf[0]) |-> $past(openCntFf[0]) >= $past(waitCnt) && gOpenFf)
    else $error("open flag set before wait time");
  a_phase_a: assert property (@(posedge clock) disable iff (!nrst)
    (pwmCntFf == 9'h000 && g_ch[0].duty != 10'h000 && drvEn) |=> sinkOutput[0])
    else $error("phase A pulse not starting at period start");
endmodule // lpbf_core

//--- core/lpbf_pkg.sv
// Constants, register map and state type for the LED PWM bank and fault core.
// Assumes a 40 MHz clock and one AHB-Lite master reaching the registers.
package lpbf_pkg;
  localparam int NCH = 36;
  localparam int NMOD = 12;
  localparam int NBANK = 3;
  localparam logic [6:0] IDX_CTRL = 7'h00;
  localparam logic [6:0] IDX_GSEL_LO = 7'h01;
  localparam logic [6:0] IDX_GSEL_HI = 7'h02;
  localparam logic [6:0] IDX_BANK = 7'h03;
  localparam logic [6:0] IDX_STAT = 7'h04;
  localparam logic [6:0] IDX_MASKG = 7'h05;
  localparam logic [6:0] IDX_OFL_LO = 7'h06;
  localparam logic [6:0] IDX_OFL_HI = 7'h07;
  localparam logic [6:0] IDX_SFL_LO = 7'h08;
  localparam logic [6:0] IDX_SFL_HI = 7'h09;
  localparam logic [6:0] IDX_OMSK_LO = 7'h0a;
  localparam logic [6:0] IDX_OMSK_HI = 7'h0b;
  localparam logic [6:0] IDX_SMSK_LO = 7'h0c;
  localparam logic [6:0] IDX_SMSK_HI = 7'h0d;
  localparam logic [6:0] IDX_INTENS = 7'h10;
  localparam logic [6:0] IDX_SHADE = 7'h20;
  localparam int CTRL_PSEN = 0;
  localparam int CTRL_WSEL = 1;
  localparam int CTRL_CLR = 3;
  localparam int CTRL_PORCLR = 4;
  localparam logic PSEN_RST = 1'b1;
  localparam logic [7:0] INTENS_RST = 8'hff;
  localparam logic [7:0] SHADE_RST = 8'h00;
  localparam logic [9:0] PWM_PERIOD = 10'h200;
  localparam logic [9:0] PWM_HALF = 10'h100;
  localparam logic [5:0] WAIT_UNIT = 6'h08;
  localparam int CLK_KHZ = 40000;
  localparam int PS_TIME_MS = 30;
  localparam int PS_CYCLES = PS_TIME_MS * CLK_KHZ;
  localparam int WARN_TIME_US = 33;
  localparam logic [10:0] WARN_CYCLES = 11'(WARN_TIME_US * CLK_KHZ / 1000);
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_NORMAL = 2'b01,
    ST_PSAVE = 2'b10
  } lpbf_state_t;
endpackage

//--- sim/lpbf_host.sv
// Host model: AHB-Lite master for the register map, plus the fault pin pull-up.
// Assumes it is the only master and that hready is the slave's hreadyout.
`timescale 1ns/100ps
module lpbf_host (
  input wire logic clock,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic faultPinOe,
  output logic faultLevel
);
  // Pull-up sets the level whenever the device lets go of the pin
  assign faultLevel = faultPinOe ? 1'b0 : 1'b1;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Call right after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // Read cycles get a toggled pattern so stale write data is never mistaken
    hwdata <= wr ? wd : ~hwdata;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  // Host duty: clear reported faults once the condition is gone
  task automatic clearFaults(input logic [31:0] ctrl);
    logic [31:0] rd;
    xfer(1'b1, 32'h0, ctrl | 32'h8, rd);
  endtask
endmodule // lpbf_host

//--- sim/led_pwm_bank_fault_control_bench.sv
// Self-checking bench for lpbf_core driven by the host model.
// Assumes the package register map and a shortened power-save limit.
`timescale 1ns/100ps
module led_pwm_bank_fault_control_bench;
  import lpbf_pkg::*;
  localparam int PSL = 50;
  typedef struct {logic [6:0] idx; logic [31:0] wd; logic [31:0] ex;} lpbf_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, analogPowerDown, faultPinOut;
  logic faultPinOe, faultLevel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NCH-1:0] openDetect = '0;
  logic [NCH-1:0] shortDetect = '0;
  logic [NCH-1:0] sinkOutput;
  logic heatDetect = 1'b0;
  logic thermalShutdown = 1'b0;
  logic supplyWarnDetect = 1'b0;
  logic supplyLowLockout = 1'b0;
  int n_errors = 0;
  int checks = 0;
  int n;
  lpbf_row_t rows[12] = '{
    '{IDX_GSEL_LO, 32'hffffffff, 32'hff}, '{IDX_GSEL_HI, 32'hffffffff, 32'h0f},
    '{IDX_GSEL_LO, 32'h0, 32'h0}, '{IDX_GSEL_HI, 32'h0, 32'h0},
    '{IDX_BANK, 32'h80302010, 32'h80302010}, '{IDX_OMSK_HI, 32'hffffffff, 32'hf},
    '{IDX_OMSK_HI, 32'h0, 32'h0}, '{7'h7f, 32'h5a, 32'h0},
    '{IDX_INTENS + 7'h0b, 32'h1ab, 32'hab}, '{IDX_STAT, 32'hff, 32'h10},
    '{IDX_CTRL, 32'h7, 32'h7}, '{IDX_CTRL, 32'h1, 32'h1}};
  always #12.5 clock = ~clock;
  assign hready = hreadyout;
  lpbf_core #(.PS_LIMIT(PSL)) i_lpbf_core (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .openDetect, .shortDetect,
    .heatDetect, .thermalShutdown, .supplyWarnDetect, .supplyLowLockout, .sinkOutput,
    .analogPowerDown, .faultPinOut, .faultPinOe);
  lpbf_host i_lpbf_host (.clock, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .faultPinOe, .faultLevel);
  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    i_lpbf_host.xfer(1'b1, {23'h0, idx, 2'b00}, d, rd);
  endtask
  task automatic rdchk(input string nm, input logic [6:0] idx, input logic [31:0] exp);
    i_lpbf_host.xfer(1'b0, {23'h0, idx, 2'b00}, 32'h0, rd);
    chk(nm, rd, exp);
  endtask
  // Detector high for exactly n sampling edges, then low again
  task automatic hold(input int kind, input int ch, input int n);
    case (kind)
      0: openDetect[ch] <= 1'b1;
      1: shortDetect[ch] <= 1'b1;
      2: heatDetect <= 1'b1;
      default: supplyWarnDetect <= 1'b1;
    endcase
    repeat (n) @(posedge clock);
    openDetect <= '0;
    shortDetect <= '0;
    heatDetect <= 1'b0;
    supplyWarnDetect <= 1'b0;
    @(posedge clock);
  endtask
  // Aligns on the base channel's rise (count zero), then checks one period of three phases
  task automatic phase(input string nm, input int b, input int d0, input int d1, input int d2);
    int dd[3];
    int e;
    int st;
    logic pv;
    logic ex;
    dd = '{d0, d1, d2};
    e = 0;
    pv = 1'b1;
    repeat (1100) begin
      @(posedge clock);
      #1;
      if (sinkOutput[b] === 1'b1 && pv === 1'b0) break;
      pv = sinkOutput[b];
    end
    for (int j = 0; j < 512; j++) begin
      for (int k = 0; k < 3; k++) begin
        st = (k == 1) ? 256 - dd[k] / 2 : ((k == 0) ? 0 : 512 - dd[k]);
        ex = (j >= st) && (j < ((k == 2) ? 512 : st + dd[k]));
        if (sinkOutput[b + k] !== ex) e++;
      end
      @(posedge clock);
      #1;
    end
    chk(nm, 32'(e), 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chk("pin after reset", 32'(faultLevel), 32'h0);
    chk("pin drive level", 32'(faultPinOut), 32'h0);
    rdchk("ctrl reset", IDX_CTRL, 32'h1);
    rdchk("select reset", IDX_GSEL_LO, 32'h0);
    rdchk("intensity reset", IDX_INTENS, 32'hff);
    for (int r = 0; r < 12; r++) begin
      wr(rows[r].idx, rows[r].wd);
      rdchk("register row", rows[r].idx, rows[r].ex);
    end
    wr(IDX_CTRL, 32'h11);
    rdchk("powerup cleared", IDX_STAT, 32'h0);
    chk("pin released", 32'(faultLevel), 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CTRL, 32'(1 + 2 * s));
      hold(0, s, (s + 1) * 8);
      rdchk("open too short", IDX_STAT, 32'h0);
      hold(0, s, (s + 1) * 8 + 1);
      rdchk("open flag", IDX_OFL_LO, 32'h1 << s);
      chk("open pin", 32'(faultLevel), 32'h0);
      i_lpbf_host.clearFaults(32'(1 + 2 * s));
      rdchk("open cleared", IDX_STAT, 32'h0);
      chk("open pin gone", 32'(faultLevel), 32'h1);
    end
    wr(IDX_CTRL, 32'h1);
    wr(IDX_SMSK_LO, 32'h4);
    hold(1, 2, 40);
    rdchk("short flag", IDX_STAT, 32'h2);
    chk("short masked", 32'(faultPinOe), 32'h0);
    wr(IDX_SHADE + 7'h02, 32'h0);
    wr(IDX_SMSK_LO, 32'h0);
    @(posedge clock);
    #1;
    chk("short shown", 32'(faultPinOe), 32'h1);
    wr(IDX_MASKG, 32'h3);
    hold(0, 33, 40);
    rdchk("open high word", IDX_OFL_HI, 32'h2);
    chk("global masks", 32'(faultPinOe), 32'h0);
    wr(IDX_MASKG, 32'h0);
    i_lpbf_host.clearFaults(32'h1);
    for (int k = 2; k < 4; k++) begin
      hold(k, 0, 1320);
      rdchk("warn too short", IDX_STAT, 32'h0);
      hold(k, 0, 1321);
      rdchk("warn flag", IDX_STAT, 32'(1 << k));
      chk("warn pin", 32'(faultPinOe), 32'h1);
      wr(IDX_MASKG, 32'(1 << k));
      @(posedge clock);
      #1;
      chk("warn masked", 32'(faultPinOe), 32'h0);
      wr(IDX_MASKG, 32'h0);
      i_lpbf_host.clearFaults(32'h1);
    end
    wr(IDX_SHADE, 32'h40);
    wr(IDX_SHADE + 7'h01, 32'h23);
    wr(IDX_SHADE + 7'h02, 32'h20);
    phase("own phases", 0, 127, 69, 63);
    wr(IDX_GSEL_HI, 32'h8);
    phase("bank phases", 33, 16, 32, 48);
    wr(IDX_BANK, 32'hff0180ff);
    phase("bank edges", 33, 508, 255, 1);
    thermalShutdown <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("drivers off", 32'(|sinkOutput), 32'h0);
    chk("shutdown pin", 32'(faultPinOe), 32'h1);
    rdchk("shutdown status", IDX_STAT, 32'h40);
    thermalShutdown <= 1'b0;
    phase("after shutdown", 33, 508, 255, 1);
    for (int m = 0; m < NMOD; m++) wr(IDX_INTENS + 7'(m), 32'h0);
    for (int c = 0; c < 3; c++) wr(IDX_SHADE + 7'(c), 32'h0);
    wr(IDX_BANK, 32'h0);
    n = 0;
    while (analogPowerDown !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("save entry", 32'(n >= PSL - 2 && n <= PSL + 10), 32'h1);
    wr(IDX_GSEL_LO, 32'h0);
    #1;
    chk("save exit", 32'(analogPowerDown), 32'h0);
    // All values still zero, so only the enable bit keeps power save away
    wr(IDX_CTRL, 32'h0);
    repeat (PSL + 10) @(posedge clock);
    #1;
    chk("save disabled", 32'(analogPowerDown), 32'h0);
    wr(IDX_GSEL_HI, 32'h5);
    supplyLowLockout <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("lockout pin", 32'(faultPinOe), 32'h1);
    supplyLowLockout <= 1'b0;
    @(posedge clock);
    rdchk("lockout reload", IDX_GSEL_HI, 32'h0);
    rdchk("powerup again", IDX_STAT, 32'h10);
    chk("response okay", 32'(hresp), 32'h0);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule // led_pwm_bank_fault_control_bench
